// *** rtl/spd_consts.vh ***
`ifndef SPD_CONSTS_VH
`define SPD_CONSTS_VH

// ****************************************************************
// Datagram layout
// ****************************************************************
`define SPD_FRAME_BITS 40
`define SPD_DATA_BITS 32
`define SPD_ADDR_BITS 7
`define SPD_WRITE_BIT 39
`define SPD_ADDR_MSB 38
`define SPD_ADDR_LSB 32
`define SPD_DATA_MSB 31

// ****************************************************************
// Status byte field positions
// ****************************************************************
`define SPD_ST_STANDSTILL 3
`define SPD_ST_STALL 2
`define SPD_ST_DRV_ERR 1
`define SPD_ST_RESET 0

// ****************************************************************
// Reset values and register addresses
// ****************************************************************
`define SPD_GLOBAL_STATUS_REGISTER_ADDR 7'h01
`define SPD_STATUS_RST 8'h00
`define SPD_DATA_RST 32'h00000000

`endif

// *** rtl/spd_regbank.v ***
`timescale 1ns/1ps
module spd_regbank #(
  parameter AW = 7,
  parameter DW = 32
) (
  // Clock and reset
  input wire mclk,
  input wire rst,
  // Write port
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [DW-1:0] wr_data,
  // Read port
  input wire [AW-1:0] rd_addr,
  output reg [DW-1:0] rd_data_q
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      rd_data_q <= {DW{1'b0}};
    end else begin
      rd_data_q <= mem[rd_addr];
    end
  end

endmodule // spd_regbank

// *** rtl/spd_port.v ***
`timescale 1ns/1ps
`include "spd_consts.vh"
// Notes on behaviour
// - Fixed 40-bit datagram: address byte, four data bytes.
// - Full 32-bit data field for every access.
// - Bit 39 write flag, seven address bits.
// - Full 40-bit reply shifted every datagram.
// - After read, reply holds addressed register.
// - After write, reply echoes write data.
// - Read: data dummies; bank register unchanged; only a read of the global status register clears its flags.
// - Status byte sits in reply bits 39..32.
// - Sample rising edge, drive after falling, MSB first.
// - Select rise takes last 40 bits; daisy chain.
// - Status: standstill, stall, error, reset; error and reset read-clear.
// - Status latched at end of each access.
module spd_port #(
  parameter GLOBAL_STATUS_REGISTER_ADDR = `SPD_GLOBAL_STATUS_REGISTER_ADDR
) (
  // Clock and reset
  input wire mclk,
  input wire rst,
  // Serial link pins
  input wire sck,
  input wire chip_select_input_n,
  input wire sdi,
  output reg sdo_q,
  output reg sdo_oe_q,
  // Device status inputs
  input wire standstill,
  input wire stall_detect_flag,
  input wire driver_error_evt,
  // Status flags
  output reg driver_error_q,
  output reg reset_flag_q,
  // Register write strobe towards the device logic
  output reg wr_stb_q,
  output reg [`SPD_ADDR_BITS-1:0] wr_addr_q,
  output reg [`SPD_DATA_BITS-1:0] wr_data_q
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // Stage 1 feeds stage 2 only; edges are found between stages 2 and 3.
  reg sck_s1_q;
  reg sck_s2_q;
  reg sck_s3_q;
  reg csn_s1_q;
  reg csn_s2_q;
  reg csn_s3_q;
  reg sdi_s1_q;
  reg sdi_s2_q;

  always @(posedge mclk) begin
    if (rst) begin
      sck_s1_q <= 1'b1;
      sck_s2_q <= 1'b1;
      sck_s3_q <= 1'b1;
      csn_s1_q <= 1'b1;
      csn_s2_q <= 1'b1;
      csn_s3_q <= 1'b1;
      sdi_s1_q <= 1'b0;
      sdi_s2_q <= 1'b0;
    end else begin
      sck_s1_q <= sck;
      sck_s2_q <= sck_s1_q;
      sck_s3_q <= sck_s2_q;
      csn_s1_q <= chip_select_input_n;
      csn_s2_q <= csn_s1_q;
      csn_s3_q <= csn_s2_q;
      sdi_s1_q <= sdi;
      sdi_s2_q <= sdi_s1_q;
    end
  end

  wire active = ~csn_s2_q;
  wire sck_rise = sck_s2_q & ~sck_s3_q & active;
  wire sck_fall = ~sck_s2_q & sck_s3_q & active;
  wire cs_start = ~csn_s2_q & csn_s3_q;
  wire cs_end = csn_s2_q & ~csn_s3_q;

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  // Unused status bits 7 to 4 are sent as zero so a host that ignores them sees a steady value.
  function [7:0] pack_status;
    input still;
    input stall;
    input drv_err;
    input rst_seen;
    begin
      pack_status = 8'h00;
      pack_status[`SPD_ST_STANDSTILL] = still;
      pack_status[`SPD_ST_STALL] = stall;
      pack_status[`SPD_ST_DRV_ERR] = drv_err;
      pack_status[`SPD_ST_RESET] = rst_seen;
    end
  endfunction

  // True when a read of this address must return and clear the sticky flags.
  function addr_is_global_status_register;
    input [`SPD_ADDR_BITS-1:0] addr;
    begin
      addr_is_global_status_register = (addr == GLOBAL_STATUS_REGISTER_ADDR);
    end
  endfunction

  // ****************************************************************
  // Command decode
  // ****************************************************************
  reg [`SPD_FRAME_BITS-1:0] shift_q;
  reg [`SPD_DATA_BITS-1:0] reply_data_q;
  reg [7:0] status_q;
  reg rd_pend_q;

  wire write_not_read_flag = shift_q[`SPD_WRITE_BIT];
  wire [`SPD_ADDR_BITS-1:0] cmd_addr = shift_q[`SPD_ADDR_MSB:`SPD_ADDR_LSB];
  wire [`SPD_DATA_BITS-1:0] cmd_data = shift_q[`SPD_DATA_MSB:0];
  wire global_status_register_read = cs_end & ~write_not_read_flag & addr_is_global_status_register(cmd_addr);
  wire bank_wr = cs_end & write_not_read_flag;
  wire [`SPD_DATA_BITS-1:0] bank_rdata;

  spd_regbank #(
    .AW(`SPD_ADDR_BITS),
    .DW(`SPD_DATA_BITS)
  ) u_bank (
    .mclk(mclk),
    .rst(rst),
    .wr_en(bank_wr),
    .wr_addr(cmd_addr),
    .wr_data(cmd_data),
    .rd_addr(cmd_addr),
    .rd_data_q(bank_rdata)
  );

  // ****************************************************************
  // Shift register and serial output
  // ****************************************************************
  // The whole 40-bit reply is preloaded when select falls, so the first bit is on the pin before the first
  // rising clock edge; later bits follow each falling edge. Bits shifted past 40 fall out on the output,
  // which is what a daisy chain needs. A frame shorter than 40 clocks still executes, with stale high bits.
  always @(posedge mclk) begin
    if (rst) begin
      shift_q <= {`SPD_FRAME_BITS{1'b0}};
      sdo_q <= 1'b0;
      sdo_oe_q <= 1'b0;
    end else begin
      sdo_oe_q <= active;
      if (cs_start) begin
        shift_q <= {status_q, reply_data_q};
        sdo_q <= status_q[7];
      end else if (sck_rise) begin
        shift_q <= {shift_q[`SPD_FRAME_BITS-2:0], sdi_s2_q};
      end else if (sck_fall) begin
        sdo_q <= shift_q[`SPD_FRAME_BITS-1];
      end
    end
  end

  // ****************************************************************
  // Access execution at end of datagram
  // ****************************************************************
  // Read data reach the reply two cycles after the synchronised select rise, so select must stay high for a few
  // clocks before the next datagram; the host timing gives more than that.
  always @(posedge mclk) begin
    if (rst) begin
      reply_data_q <= `SPD_DATA_RST;
      rd_pend_q <= 1'b0;
      wr_stb_q <= 1'b0;
      wr_addr_q <= {`SPD_ADDR_BITS{1'b0}};
      wr_data_q <= {`SPD_DATA_BITS{1'b0}};
    end else begin
      wr_stb_q <= bank_wr;
      rd_pend_q <= 1'b0;
      if (cs_end) begin
        if (write_not_read_flag) begin
          wr_addr_q <= cmd_addr;
          wr_data_q <= cmd_data;
          reply_data_q <= cmd_data;
        end else if (global_status_register_read) begin
          reply_data_q <= {{(`SPD_DATA_BITS-2){1'b0}}, driver_error_q, reset_flag_q};
        end else begin
          rd_pend_q <= 1'b1;
        end
      end
      if (rd_pend_q) begin
        reply_data_q <= bank_rdata;
      end
    end
  end

  // ****************************************************************
  // Status flags
  // ****************************************************************
  // A new error event in the cycle of the clearing read is kept: set wins over clear.
  always @(posedge mclk) begin
    if (rst) begin
      driver_error_q <= 1'b0;
      reset_flag_q <= 1'b1;
      status_q <= `SPD_STATUS_RST;
    end else begin
      if (driver_error_evt) begin
        driver_error_q <= 1'b1;
      end else if (global_status_register_read) begin
        driver_error_q <= 1'b0;
      end
      if (global_status_register_read) begin
        reset_flag_q <= 1'b0;
      end
      if (cs_end) begin
        status_q <= pack_status(standstill, stall_detect_flag,
                                driver_error_q | driver_error_evt, reset_flag_q);
      end
    end
  end

endmodule // spd_port

// *** tb/spd_port_chk.sv ***
`timescale 1ns/1ps
module spd_port_chk (
  // Clock and reset
  input wire mclk,
  input wire rst,
  // Link
  input wire chip_select_input_n,
  input wire sdo_oe_q,
  // Status
  input wire driver_error_evt,
  input wire driver_error_q,
  input wire reset_flag_q,
  // Writes
  input wire wr_stb_q,
  input wire [6:0] wr_addr_q,
  input wire [31:0] wr_data_q
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Ranges allow for the two-flop synchronisers on the select pin.
  a_oe_on_select: assert property ($fell(chip_select_input_n) |-> ##[1:4] sdo_oe_q)
    else $error("output enable late");
  a_oe_off_select: assert property ($rose(chip_select_input_n) |-> ##[1:4] !sdo_oe_q)
    else $error("output enable stuck");
  a_stb_one_cycle: assert property (wr_stb_q |=> !wr_stb_q)
    else $error("write strobe too long");
  a_stb_after_frame: assert property (wr_stb_q |-> !sdo_oe_q)
    else $error("write inside frame");
  a_wr_hold: assert property (!wr_stb_q |-> $stable({wr_addr_q, wr_data_q}))
    else $error("write regs moved");
  a_err_set: assert property (driver_error_evt |-> ##[1:2] driver_error_q)
    else $error("error flag not set");
  a_err_cause: assert property ($rose(driver_error_q) |-> $past(driver_error_evt) || $past(driver_error_evt, 2))
    else $error("error flag without event");
  a_err_clear: assert property ($fell(driver_error_q) |-> !sdo_oe_q)
    else $error("error flag cleared in frame");
  a_rflag_clear: assert property ($fell(reset_flag_q) |-> !sdo_oe_q)
    else $error("reset flag cleared in frame");
  a_rflag_set: assert property (!$rose(reset_flag_q))
    else $error("reset flag set without reset");
  cover property (wr_stb_q);
  cover property ($fell(reset_flag_q));
  cover property ($fell(driver_error_q));
endmodule // spd_port_chk

bind spd_port spd_port_chk u_chk (.*);

// *** tb/spd_host.sv ***
`timescale 1ns/1ps
module spd_host (
  // Link
  output logic sck,
  output logic chip_select_input_n,
  output logic sdi,
  input wire sdo_q,
  input wire sdo_oe_q
);
  initial begin
    sck = 1'b1;
    chip_select_input_n = 1'b1;
    sdi = 1'b0;
  end
  // The clock stands high between frames; released data flips so a stale bit is never mistaken for a driven one.
  // A released output reads as the inverse of its last value, so a missing enable shows up as wrong data.
  task automatic xfer_bits(input logic [47:0] tx, input int nb, output logic [47:0] rx);
    rx = '0;
    chip_select_input_n = 1'b0;
    #40;
    for (int i = nb - 1; i >= 0; i--) begin
      sck = 1'b0;
      sdi = tx[i];
      #40;
      sck = 1'b1;
      rx[i] = sdo_oe_q ? sdo_q : ~sdo_q;
      #40;
    end
    chip_select_input_n = 1'b1;
    sdi = ~sdi;
    #80;
  endtask
  task automatic xfer(input logic [39:0] tx, output logic [39:0] rx);
    logic [47:0] r48;
    xfer_bits({8'h00, tx}, 40, r48);
    rx = r48[39:0];
  endtask
endmodule // spd_host

// *** tb/tb_spd_register_datagram_port.sv ***
`timescale 1ns/1ps
`include "spd_consts.vh"
module tb_spd_register_datagram_port;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic standstill = 1'b1;
  logic stall_detect_flag = 1'b0;
  logic driver_error_evt = 1'b0;
  wire sck, chip_select_input_n, sdi, sdo_q, sdo_oe_q, driver_error_q, reset_flag_q, wr_stb_q;
  wire [6:0] wr_addr_q;
  wire [31:0] wr_data_q;
  logic [39:0] rx;
  int n_errors = 0;
  int comparisons = 0;
  int cyc = 0;
  localparam logic [31:0] D1 = 32'hA5C30F01;
  localparam logic [31:0] D2 = 32'h5A3CF0E2;
  initial forever #2 mclk = ~mclk;
  spd_host host (.*);
  spd_port dut (.*);
  task automatic cmp(input logic [39:0] got, input logic [39:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    if (n_errors == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic t_reset_reply;
    host.xfer({1'b0, `SPD_GLOBAL_STATUS_REGISTER_ADDR, 32'h0}, rx);
    cmp(rx, {`SPD_STATUS_RST, `SPD_DATA_RST});
  endtask
  task automatic t_write_echo;
    host.xfer({8'h85, D1}, rx);
    cmp(rx, {8'h09, 32'h00000001});
    cmp({wr_addr_q, wr_data_q, reset_flag_q}, {7'h05, D1, 1'b0});
    host.xfer({8'h05, 32'h0}, rx);
    cmp(rx, {8'h08, D1});
  endtask
  task automatic t_status_flags;
    @(negedge mclk) driver_error_evt = 1'b1;
    stall_detect_flag = 1'b1;
    @(negedge mclk) driver_error_evt = 1'b0;
    host.xfer({1'b0, `SPD_GLOBAL_STATUS_REGISTER_ADDR, 32'h0}, rx);
    cmp(rx, {8'h08, D1});
    host.xfer({8'h05, 32'h0}, rx);
    cmp(rx, {8'h0E, 32'h00000002});
    cmp({39'h0, driver_error_q}, 40'h0);
  endtask
  task automatic t_daisy_chain;
    logic [47:0] r48;
    host.xfer_bits({8'h3C, 8'h86, D2}, 48, r48);
    cmp(r48[47:8], {8'h0C, D1});
    cmp({32'h0, r48[7:0]}, {32'h0, 8'h3C});
    cmp({wr_addr_q, wr_data_q, wr_stb_q}, {7'h06, D2, 1'b0});
    host.xfer({8'h06, 32'h0}, rx);
    cmp(rx, {8'h0C, D2});
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      finish_test;
    end
  end
  initial begin
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    repeat (4) @(negedge mclk);
    t_reset_reply();
    t_write_echo();
    t_status_flags();
    t_daisy_chain();
    finish_test;
  end
endmodule // tb_spd_register_datagram_port
